// [rtl/via_core.sv]
// Vectored interrupt acceptance: status word, pending logic and entry sequence
`timescale 1ns/1ps
`include "via_map.svh"
module via_core
  import via_pkg::*;
#(
  parameter int NSRC = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_penult,
  input wire logic instr_last,
  input wire logic alu_flag_we,
  input wire logic alu_zero,
  input wire logic alu_aux,
  input wire logic alu_carry,
  input wire logic psw_wr_en,
  input wire logic [7:0] psw_wr_data,
  input wire logic psw_bit_we,
  input wire logic [2:0] psw_bit_sel,
  input wire logic psw_bit_val,
  input wire logic accept_on_instruction,
  input wire logic accept_off_instruction,
  input wire logic service_return_instruction,
  input wire logic [7:0] service_return_instruction_psw_data,
  input wire logic sfr_wr_en,
  input wire logic sfr_bit_we,
  input wire logic sfr_rd_en,
  input wire logic sfr_sel,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  input wire logic [7:0] sfr_wr_data,
  input wire logic [NSRC-1:0] maskable_req_in,
  input wire logic key_return_request,
  input wire logic watchdog_nmi_request,
  input wire logic stack_ready,
  output logic [7:0] program_status_flags,
  output logic [7:0] sfr_rd_data,
  output logic svc_busy,
  output logic push_psw_valid,
  output logic [7:0] push_psw_data,
  output logic push_pc_valid,
  output logic load_pc_valid,
  output logic [15:0] load_pc_addr,
  output logic nmi_active
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] psw_r;
  logic [7:0] psw_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic [1:0] nmi_pend_r;
  logic [1:0] nmi_pend_nxt;
  logic nmi_act_r;
  logic nmi_act_nxt;
  logic acc_instr_r;
  logic acc_instr_nxt;
  logic defer_r;
  logic defer_nxt;
  logic take_r;
  logic take_nxt;
  via_state_type state_r;
  via_state_type state_nxt;
  via_kind_type kind_r;
  via_kind_type kind_nxt;
  logic [15:0] vec_r;
  logic [15:0] vec_nxt;
  logic sfr_access;
  logic hold;
  logic ie;
  logic [NSRC-1:0] eligible;
  logic mask_any;
  logic nmi_ok;
  logic start;
  logic grant_valid;
  via_idx_type grant_idx;
  logic [NSRC-1:0] ack_clr;

  via_flag_if #(.NSRC(NSRC)) fl ();

  // ----------------------------------------------------------------
  // Flag registers and arbiter
  // ----------------------------------------------------------------
  via_flags #(
    .NSRC(NSRC)
  ) u_flags (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .fl(fl.owner)
  );

  assign fl.wr_en = sfr_wr_en;
  assign fl.bit_we = sfr_bit_we;
  assign fl.sel = sfr_sel;
  assign fl.bit_sel = sfr_bit_sel;
  assign fl.bit_val = sfr_bit_val;
  assign fl.wr_data = sfr_wr_data;
  assign fl.hw_set = maskable_req_in;
  assign fl.ack_clr = ack_clr;

  assign ie = psw_r[`VIA_PSW_IE];
  assign eligible = fl.req_flags & ~fl.mask_flags;
  assign mask_any = grant_valid && ie;

  via_arbiter #(
    .NSRC(NSRC)
  ) u_arb (
    .eligible(eligible),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  // ----------------------------------------------------------------
  // Hold logic around flag register access
  // ----------------------------------------------------------------
  assign sfr_access = sfr_wr_en | sfr_bit_we | sfr_rd_en;
  assign hold = sfr_access | acc_instr_r | defer_r;

  always_comb begin
    acc_instr_nxt = acc_instr_r | sfr_access;
    defer_nxt = defer_r;
    if (instr_last) begin
      acc_instr_nxt = 1'b0;
      defer_nxt = acc_instr_r | sfr_access;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      acc_instr_r <= 1'b0;
      defer_r <= 1'b0;
    end else begin
      acc_instr_r <= acc_instr_nxt;
      defer_r <= defer_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Decision at the instruction boundary
  // ----------------------------------------------------------------
  // a running non-maskable routine blocks the next one
  assign nmi_ok = (|nmi_pend_r) && !nmi_act_r;

  // a later flag waits for the next instruction
  always_comb begin
    take_nxt = take_r;
    if (instr_penult) begin
      take_nxt = (nmi_ok || mask_any) && !hold;
    end
    if (instr_last) begin
      take_nxt = 1'b0;
    end
  end

  // Start only when the earlier decision still holds
  assign start = instr_last && take_r && !hold && (state_r == VIA_IDLE) &&
                 (nmi_ok || mask_any);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      take_r <= 1'b0;
    end else begin
      take_r <= take_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Vector lookup
  // ----------------------------------------------------------------
  // index order sets priority
  function automatic logic [15:0] via_vector(input via_idx_type idx);
    logic [15:0] v;
    v = `VIA_VEC_WDT;
    case (idx)
      `VIA_SRC_WDT: v = `VIA_VEC_WDT;
      `VIA_SRC_TMA: v = `VIA_VEC_TMA;
      `VIA_SRC_TMB: v = `VIA_VEC_TMB;
      `VIA_SRC_LVI: v = `VIA_VEC_LVI;
      `VIA_SRC_WRC: v = `VIA_VEC_WRC;
      default: v = `VIA_VEC_WDT;
    endcase
    return v;
  endfunction : via_vector

  // ----------------------------------------------------------------
  // Source selection and request flag clearing
  // ----------------------------------------------------------------
  always_comb begin
    kind_nxt = kind_r;
    vec_nxt = vec_r;
    ack_clr = '0;
    nmi_pend_nxt = nmi_pend_r;
    if (start) begin
      // non-maskable first, key input ahead of watchdog
      if (nmi_ok && nmi_pend_r[0]) begin
        kind_nxt = VIA_KIND_KEY;
        vec_nxt = `VIA_VEC_KEY;
        nmi_pend_nxt[0] = 1'b0;
      end else if (nmi_ok) begin
        kind_nxt = VIA_KIND_WDT;
        vec_nxt = `VIA_VEC_WDT;
        nmi_pend_nxt[1] = 1'b0;
      end else begin
        kind_nxt = VIA_KIND_MASK;
        vec_nxt = via_vector(grant_idx);
        // flag dropped before the routine starts
        ack_clr[grant_idx] = 1'b1;
      end
    end
    // new request beats a clear in the same cycle
    if (key_return_request) begin
      nmi_pend_nxt[0] = 1'b1;
    end
    if (watchdog_nmi_request) begin
      nmi_pend_nxt[1] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kind_r <= VIA_KIND_MASK;
      vec_r <= `VIA_VEC_KEY;
      nmi_pend_r <= 2'h0;
    end else begin
      kind_r <= kind_nxt;
      vec_r <= vec_nxt;
      nmi_pend_r <= nmi_pend_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Entry sequence
  // ----------------------------------------------------------------
  // status word, then PC, then vector load
  // entry adds three steps after the boundary
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      VIA_IDLE: begin
        if (start) begin
          state_nxt = VIA_PUSH_PSW;
        end
      end
      VIA_PUSH_PSW: begin
        if (stack_ready) begin
          state_nxt = VIA_PUSH_PC;
        end
      end
      VIA_PUSH_PC: begin
        if (stack_ready) begin
          state_nxt = VIA_LOAD;
        end
      end
      VIA_LOAD: begin
        state_nxt = VIA_IDLE;
      end
      default: begin
        state_nxt = VIA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= VIA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Non-maskable service tracking
  // ----------------------------------------------------------------
  // active from the vector load until return
  always_comb begin
    nmi_act_nxt = nmi_act_r;
    if (service_return_instruction) begin
      nmi_act_nxt = 1'b0;
    end
    if (state_r == VIA_LOAD && kind_r != VIA_KIND_MASK) begin
      nmi_act_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nmi_act_r <= 1'b0;
    end else begin
      nmi_act_r <= nmi_act_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Lowest to highest precedence; the CPU is stalled during entry
  always_comb begin
    psw_nxt = psw_r;
    if (alu_flag_we) begin
      psw_nxt[`VIA_PSW_Z] = alu_zero;
      psw_nxt[`VIA_PSW_AC] = alu_aux;
      psw_nxt[`VIA_PSW_CY] = alu_carry;
    end
    if (accept_on_instruction) begin
      psw_nxt[`VIA_PSW_IE] = 1'b1;
    end
    if (accept_off_instruction) begin
      psw_nxt[`VIA_PSW_IE] = 1'b0;
    end
    if (psw_bit_we) begin
      psw_nxt[psw_bit_sel] = psw_bit_val;
    end
    if (psw_wr_en) begin
      psw_nxt = psw_wr_data;
    end
    // popped status word restores the enable
    if (service_return_instruction) begin
      psw_nxt = service_return_instruction_psw_data;
    end
    // enable cleared once the PC is stacked
    if (state_r == VIA_PUSH_PC && stack_ready) begin
      psw_nxt[`VIA_PSW_IE] = 1'b0;
    end
    // fixed bits forced whatever was written
    psw_nxt = (psw_nxt & `VIA_PSW_KEEP) | `VIA_PSW_RESET;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      psw_r <= `VIA_PSW_RESET;
    end else begin
      psw_r <= psw_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Flag register read port
  // ----------------------------------------------------------------
  // Unused upper bits read as their required fill
  always_comb begin
    rd_nxt = rd_r;
    if (sfr_rd_en) begin
      if (sfr_sel == `VIA_SEL_MASK) begin
        rd_nxt = {`VIA_MASK_UPPER, fl.mask_flags};
      end else begin
        rd_nxt = {`VIA_REQ_UPPER, fl.req_flags};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_r <= 8'h00;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign program_status_flags = psw_r;
  assign sfr_rd_data = rd_r;
  assign svc_busy = (state_r != VIA_IDLE);
  assign push_psw_valid = (state_r == VIA_PUSH_PSW);
  assign push_psw_data = psw_r;
  assign push_pc_valid = (state_r == VIA_PUSH_PC);
  assign load_pc_valid = (state_r == VIA_LOAD);
  assign load_pc_addr = vec_r;
  assign nmi_active = nmi_act_r;

endmodule : via_core

// [include/via_map.svh]
// Constants of the vectored interrupt acceptance block
`ifndef VIA_MAP_SVH
`define VIA_MAP_SVH
`define VIA_PSW_RESET 8'h02
`define VIA_PSW_KEEP 8'hD1
`define VIA_PSW_IE 7
`define VIA_PSW_Z 6
`define VIA_PSW_AC 4
`define VIA_PSW_CY 0
`define VIA_REQ_RESET 5'h00
`define VIA_MASK_RESET 5'h1F
`define VIA_REQ_UPPER 3'h0
`define VIA_MASK_UPPER 3'h7
`define VIA_SEL_REQ 1'b0
`define VIA_SEL_MASK 1'b1
`define VIA_VEC_KEY 16'h0002
`define VIA_VEC_WDT 16'h0004
`define VIA_VEC_TMA 16'h0006
`define VIA_VEC_TMB 16'h0008
`define VIA_VEC_LVI 16'h000A
`define VIA_VEC_WRC 16'h000C
`define VIA_SRC_WDT 3'h0
`define VIA_SRC_TMA 3'h1
`define VIA_SRC_TMB 3'h2
`define VIA_SRC_LVI 3'h3
`define VIA_SRC_WRC 3'h4
`endif

// [include/via_pkg.sv]
// Types shared by the interrupt acceptance modules
package via_pkg;
  localparam int VIA_NUM_SRC = 5;
  typedef enum logic [1:0] {VIA_IDLE, VIA_PUSH_PSW, VIA_PUSH_PC, VIA_LOAD} via_state_type;
  typedef enum logic [1:0] {VIA_KIND_KEY, VIA_KIND_WDT, VIA_KIND_MASK} via_kind_type;
  typedef logic [2:0] via_idx_type;
endpackage : via_pkg

// [include/via_flag_if.sv]
// Carrier between the acceptance core and the flag registers
`timescale 1ns/1ps
interface via_flag_if #(parameter int NSRC = 5);
  logic wr_en;
  logic bit_we;
  logic sel;
  logic [2:0] bit_sel;
  logic bit_val;
  logic [7:0] wr_data;
  logic [NSRC-1:0] hw_set;
  logic [NSRC-1:0] ack_clr;
  logic [NSRC-1:0] req_flags;
  logic [NSRC-1:0] mask_flags;
  modport owner (
    input wr_en, bit_we, sel, bit_sel, bit_val, wr_data, hw_set, ack_clr,
    output req_flags, mask_flags
  );
  modport user (
    output wr_en, bit_we, sel, bit_sel, bit_val, wr_data, hw_set, ack_clr,
    input req_flags, mask_flags
  );
endinterface : via_flag_if

// [rtl/via_arbiter.sv]
// Fixed priority pick among eligible maskable sources
`timescale 1ns/1ps
module via_arbiter
  import via_pkg::*;
#(
  parameter int NSRC = 5
) (
  input wire logic [NSRC-1:0] eligible,
  output logic grant_valid,
  output via_idx_type grant_idx
);
  logic [NSRC-1:0] grant_oh;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_pick
      if (gi == 0) begin : g_first
        assign grant_oh[gi] = eligible[gi];
      end else begin : g_rest
        assign grant_oh[gi] = eligible[gi] & ~(|eligible[gi-1:0]);
      end
    end
  endgenerate
  always_comb begin
    grant_idx = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (grant_oh[i]) begin
        grant_idx = via_idx_type'(i);
      end
    end
  end
  assign grant_valid = |eligible;
endmodule : via_arbiter

// [rtl/via_flags.sv]
// Request flag and mask flag registers of the maskable sources
`timescale 1ns/1ps
`include "via_map.svh"
module via_flags
  import via_pkg::*;
#(
  parameter int NSRC = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  via_flag_if.owner fl
);
  logic [NSRC-1:0] req_r;
  logic [NSRC-1:0] req_nxt;
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] mask_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_bit
      logic hit;
      assign hit = fl.bit_we && (fl.bit_sel == via_idx_type'(gi));
      always_comb begin
        req_nxt[gi] = req_r[gi] & ~fl.ack_clr[gi];
        if (fl.wr_en && fl.sel == `VIA_SEL_REQ) begin
          req_nxt[gi] = fl.wr_data[gi];
        end else if (hit && fl.sel == `VIA_SEL_REQ) begin
          req_nxt[gi] = fl.bit_val;
        end
        if (fl.hw_set[gi]) begin
          req_nxt[gi] = 1'b1;
        end
        mask_nxt[gi] = mask_r[gi];
        if (fl.wr_en && fl.sel == `VIA_SEL_MASK) begin
          mask_nxt[gi] = fl.wr_data[gi];
        end else if (hit && fl.sel == `VIA_SEL_MASK) begin
          mask_nxt[gi] = fl.bit_val;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      req_r <= `VIA_REQ_RESET;
      mask_r <= `VIA_MASK_RESET;
    end else begin
      req_r <= req_nxt;
      mask_r <= mask_nxt;
    end
  end
  assign fl.req_flags = req_r;
  assign fl.mask_flags = mask_r;
endmodule : via_flags

// [tb/via_core_asserts.sv]
// Concurrent checks on the ports of the acceptance core
`timescale 1ns/1ps
module via_core_asserts #(
  parameter int NSRC = 5
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic instr_last,
  input wire logic psw_wr_en,
  input wire logic [7:0] psw_wr_data,
  input wire logic psw_bit_we,
  input wire logic accept_on_instruction,
  input wire logic accept_off_instruction,
  input wire logic service_return_instruction,
  input wire logic [7:0] service_return_instruction_psw_data,
  input wire logic stack_ready,
  input wire logic [7:0] program_status_flags,
  input wire logic svc_busy,
  input wire logic push_psw_valid,
  input wire logic [7:0] push_psw_data,
  input wire logic push_pc_valid,
  input wire logic load_pc_valid,
  input wire logic nmi_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_psw_taken;
    push_psw_valid && stack_ready;
  endsequence
  sequence s_pc_taken;
    push_pc_valid && stack_ready;
  endsequence
  sequence s_load_once;
    load_pc_valid && !program_status_flags[7] ##1 !load_pc_valid;
  endsequence
  a_reset_value: assert property (!$past(nrst) |-> program_status_flags == 8'h02)
    else $error("status word not 02H after reset");
  a_fixed_bits: assert property ({program_status_flags[5], program_status_flags[3:1]} == 4'h1)
    else $error("fixed status bits wrong");
  a_byte_write: assert property (
    psw_wr_en && !service_return_instruction && !svc_busy
    |=> program_status_flags == (($past(psw_wr_data) & 8'hD1) | 8'h02))
    else $error("status byte write lost");
  a_enable_on: assert property (
    accept_on_instruction && !accept_off_instruction && !psw_bit_we && !psw_wr_en
    && !service_return_instruction && !svc_busy |=> program_status_flags[7])
    else $error("enable instruction did not set enable");
  a_enable_off: assert property (
    accept_off_instruction && !psw_bit_we && !psw_wr_en && !service_return_instruction
    |=> !program_status_flags[7])
    else $error("disable instruction did not clear enable");
  a_return_restore: assert property (
    service_return_instruction && !svc_busy
    |=> program_status_flags == (($past(service_return_instruction_psw_data) & 8'hD1) | 8'h02))
    else $error("return did not restore status word");
  a_entry_order: assert property (s_psw_taken |=> push_pc_valid && !push_psw_valid)
    else $error("program counter push did not follow status push");
  a_entry_clear: assert property (s_pc_taken |=> s_load_once)
    else $error("vector load or enable clear missing");
  a_push_hold: assert property (
    push_psw_valid && !stack_ready |=> push_psw_valid && $stable(push_psw_data))
    else $error("status push dropped while stalled");
  a_start_boundary: assert property ($rose(push_psw_valid) |-> $past(instr_last))
    else $error("entry began off an instruction boundary");
  a_nmi_hold: assert property (nmi_active && !service_return_instruction |=> nmi_active)
    else $error("non-maskable routine ended without return");
endmodule : via_core_asserts

bind via_core via_core_asserts #(.NSRC(NSRC)) i_asserts (.clk_sys, .nrst, .instr_last,
  .psw_wr_en, .psw_wr_data, .psw_bit_we, .accept_on_instruction, .accept_off_instruction,
  .service_return_instruction, .service_return_instruction_psw_data, .stack_ready, .program_status_flags,
  .svc_busy, .push_psw_valid, .push_psw_data, .push_pc_valid, .load_pc_valid, .nmi_active);

// [tb/via_cpu_model.sv]
// Behavioural CPU sequencer: instruction boundaries and stack answers
`timescale 1ns/1ps
module via_cpu_model #(
  parameter int ILEN = 6
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic svc_busy,
  input wire logic stall,
  output logic instr_penult,
  output logic instr_last,
  output logic stack_ready
);
  int cnt = 1;
  // Instructions freeze while the entry sequence owns the stack
  always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt = 1;
    end else if (cnt == ILEN) begin
      cnt = 1;
    end else if (!svc_busy) begin
      cnt = cnt + 1;
    end
  end
  assign instr_penult = nrst && !svc_busy && cnt == ILEN - 1;
  assign instr_last = nrst && !svc_busy && cnt == ILEN;
  // Slow stack answers come from the bench stall pattern
  assign stack_ready = !stall;
endmodule : via_cpu_model

// [tb/via_core_tb.sv]
// Self-checking bench for the acceptance core
`timescale 1ns/1ps
module via_core_tb;
  import via_pkg::*;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic instr_penult, instr_last, alu_flag_we, alu_zero, alu_aux, alu_carry, stall;
  logic psw_wr_en, psw_bit_we, psw_bit_val, accept_on_instruction, accept_off_instruction;
  logic service_return_instruction, sfr_wr_en, sfr_bit_we, sfr_rd_en, sfr_sel, sfr_bit_val;
  logic key_return_request, watchdog_nmi_request, stack_ready, svc_busy, nmi_active;
  logic push_psw_valid, push_pc_valid, load_pc_valid;
  logic [2:0] psw_bit_sel, sfr_bit_sel;
  logic [4:0] maskable_req_in;
  logic [7:0] psw_wr_data, service_return_instruction_psw_data, sfr_wr_data, program_status_flags;
  logic [7:0] sfr_rd_data, push_psw_data;
  logic [15:0] load_pc_addr;
  logic [31:0] seed = 32'h9B997DD6;
  logic [31:0] st_seed = 32'h9B997DD6;
  int error_cnt = 0;
  int n_compared = 0;

  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    st_seed = lfsr(lfsr(st_seed));
    stall = st_seed[3] & st_seed[7];
  end

  via_cpu_model #(.ILEN(6)) i_cpu (.clk_sys, .nrst, .svc_busy, .stall, .instr_penult,
    .instr_last, .stack_ready);
  via_core #(.NSRC(5)) i_dut (.clk_sys, .nrst, .instr_penult, .instr_last, .alu_flag_we,
    .alu_zero, .alu_aux, .alu_carry, .psw_wr_en, .psw_wr_data, .psw_bit_we, .psw_bit_sel,
    .psw_bit_val, .accept_on_instruction, .accept_off_instruction,
    .service_return_instruction, .service_return_instruction_psw_data, .sfr_wr_en, .sfr_bit_we, .sfr_rd_en,
    .sfr_sel, .sfr_bit_sel, .sfr_bit_val, .sfr_wr_data, .maskable_req_in, .key_return_request,
    .watchdog_nmi_request, .stack_ready, .program_status_flags, .sfr_rd_data, .svc_busy,
    .push_psw_valid, .push_psw_data, .push_pc_valid, .load_pc_valid, .load_pc_addr,
    .nmi_active);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] psw_exp(input logic [7:0] d);
    return (d & 8'hD1) | 8'h02;
  endfunction : psw_exp
  // Lowest index wins among simultaneous maskable requests
  function automatic logic [15:0] vec_exp(input logic [4:0] r);
    for (int i = 0; i < 5; i++) begin
      if (r[i]) return 16'h0004 + 16'(2 * i);
    end
    return 16'h0000;
  endfunction : vec_exp

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // Trailing idle cycle keeps a strobe from being lowered and raised in one step
  task automatic pulse(ref logic s);
    s = 1'h1;
    tick();
    s = 1'h0;
    tick();
  endtask : pulse
  task automatic wait_load(output logic [15:0] a, output logic [7:0] p);
    int n;
    n = 0;
    while (load_pc_valid !== 1'h1) begin
      if (push_psw_valid === 1'h1) p = push_psw_data;
      tick();
      n++;
      if (n > 80) begin
        chk("vector load wait", 16'h0000, 16'h0001);
        close_out();
      end
    end
    a = load_pc_addr;
    chk("enable at entry", 16'(program_status_flags[7]), 16'h0000);
    tick();
  endtask : wait_load
  task automatic no_load(input int n, input logic spam);
    int hits;
    hits = 0;
    sfr_rd_en = spam;
    repeat (n) begin
      tick();
      if (load_pc_valid === 1'h1) hits++;
    end
    sfr_rd_en = 1'h0;
    chk("early vector load", 16'(hits), 16'h0000);
  endtask : no_load
  task automatic ret(input logic [7:0] p);
    service_return_instruction_psw_data = p;
    pulse(service_return_instruction);
    chk("restored status", 16'(program_status_flags), 16'(psw_exp(p)));
  endtask : ret
  task automatic serve(input logic [4:0] r);
    logic [15:0] a;
    logic [7:0] p;
    while (r != 5'h00) begin
      wait_load(a, p);
      chk("vector", a, vec_exp(r));
      chk("saved enable", 16'(p[7]), 16'h0001);
      sfr_sel = 1'h0;
      pulse(sfr_rd_en);
      r = r & (r - 5'h01);
      chk("request flags", 16'(sfr_rd_data), 16'({3'h0, r}));
      ret(p);
    end
  endtask : serve

  initial begin
    logic [15:0] a;
    logic [7:0] p;
    logic [7:0] e;
    logic [4:0] r;
    {psw_wr_en, psw_bit_we, psw_bit_val, accept_on_instruction, accept_off_instruction} = '0;
    {service_return_instruction, sfr_wr_en, sfr_bit_we, sfr_rd_en, sfr_sel, sfr_bit_val} = '0;
    {alu_flag_we, alu_zero, alu_aux, alu_carry, key_return_request, watchdog_nmi_request} = '0;
    {psw_bit_sel, sfr_bit_sel, maskable_req_in, psw_wr_data, service_return_instruction_psw_data, sfr_wr_data} = '0;
    tick(20);
    nrst = 1'h1;
    tick();
    chk("status after reset", 16'(program_status_flags), 16'h0002);
    sfr_sel = 1'h1;
    pulse(sfr_rd_en);
    chk("masks after reset", 16'(sfr_rd_data), 16'h00FF);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      psw_wr_data = seed[7:0];
      pulse(psw_wr_en);
      chk("byte write", 16'(program_status_flags), 16'(psw_exp(seed[7:0])));
      e = psw_exp(seed[7:0]);
      e[i] = seed[9];
      psw_bit_sel = 3'(i);
      psw_bit_val = seed[9];
      pulse(psw_bit_we);
      chk("bit write", 16'(program_status_flags), 16'(psw_exp(e)));
    end
    psw_wr_data = 8'h00;
    pulse(psw_wr_en);
    {alu_zero, alu_aux, alu_carry} = 3'h7;
    pulse(alu_flag_we);
    chk("result flags", 16'(program_status_flags), 16'h0053);
    pulse(accept_on_instruction);
    chk("enable on", 16'(program_status_flags), 16'h00D3);
    pulse(accept_off_instruction);
    chk("enable off", 16'(program_status_flags), 16'h0053);
    // Masked requests wait, then drain in priority order
    pulse(accept_on_instruction);
    maskable_req_in = 5'h1F;
    tick();
    maskable_req_in = 5'h00;
    no_load(40, 1'h0);
    sfr_sel = 1'h1;
    for (int i = 0; i < 5; i++) begin
      sfr_bit_sel = 3'(i);
      pulse(sfr_bit_we);
    end
    serve(5'h1F);
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      r = (seed[4:0] == 5'h00) ? 5'h10 : seed[4:0];
      maskable_req_in = r;
      tick();
      maskable_req_in = 5'h00;
      serve(r);
    end
    pulse(accept_off_instruction);
    maskable_req_in = 5'h04;
    tick();
    maskable_req_in = 5'h00;
    no_load(40, 1'h0);
    pulse(accept_on_instruction);
    serve(5'h04);
    pulse(accept_off_instruction);
    maskable_req_in = 5'h08;
    sfr_rd_en = 1'h1;
    pulse(accept_on_instruction);
    // Request must be a pulse, else the source re-flags itself after each accept
    maskable_req_in = 5'h00;
    no_load(40, 1'h1);
    serve(5'h08);
    pulse(accept_off_instruction);
    pulse(key_return_request);
    wait_load(a, p);
    chk("key vector", a, 16'h0002);
    chk("routine running", 16'(nmi_active), 16'h0001);
    pulse(key_return_request);
    no_load(40, 1'h0);
    ret(p);
    wait_load(a, p);
    chk("held key vector", a, 16'h0002);
    ret(p);
    pulse(watchdog_nmi_request);
    wait_load(a, p);
    chk("watchdog vector", a, 16'h0004);
    ret(p);
    pulse(accept_on_instruction);
    {key_return_request, maskable_req_in} = 6'h22;
    tick();
    {key_return_request, maskable_req_in} = 6'h00;
    wait_load(a, p);
    chk("non-maskable first", a, 16'h0002);
    ret(p);
    serve(5'h02);
    // Whole byte writes of both flag registers
    sfr_sel = 1'h1;
    sfr_wr_data = 8'hFF;
    pulse(sfr_wr_en);
    sfr_sel = 1'h0;
    sfr_wr_data = 8'h1F;
    pulse(sfr_wr_en);
    pulse(sfr_rd_en);
    chk("request byte write", 16'(sfr_rd_data), 16'h001F);
    sfr_sel = 1'h1;
    pulse(sfr_rd_en);
    chk("mask byte write", 16'(sfr_rd_data), 16'h00FF);
    no_load(40, 1'h0);
    close_out();
  end
endmodule : via_core_tb
